//--- include/yeecfg_pkg.sv
// Constants and types shared by the tone, chroma and edge configuration block
package yeecfg_pkg;
  // ----------------------------------------------------------------
  // Bus and sample widths
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PIX_W     = 8;
  localparam int CHR_W     = 9;
  localparam int OFFSET_W  = 11;
  localparam int COEF_W    = 10;
  localparam int SHIFT_W   = 4;
  localparam int FMT_W     = 2;
  localparam int TAPS      = 9;
  localparam int TABLE_N   = 16;
  localparam int TABLE_W   = 8;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_LUMA_OUTPUT_OFFSET      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BLUE_DIFF_OUTPUT_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RED_DIFF_OUTPUT_OFFSET  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CHROMA_PHASE_CONTROL    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TONE_ENHANCE_ENABLE     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TONE_ENHANCE_METHOD     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EDGE_ENABLE             = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EDGE_METHOD             = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_EDGE_HPF_SHIFT          = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_EDGE_HPF_COEF_BASE      = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_FORMAT_SELECT    = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_PIPE_STATUS             = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_TONE_TABLE_BASE         = 8'h80;
  localparam logic [1:0]        TABLE_REGION                = 2'h2;
  // ----------------------------------------------------------------
  // Field positions, reset values and codes
  // ----------------------------------------------------------------
  localparam int PHS_POS_BIT  = 0;
  localparam int PHS_LPF_BIT  = 1;
  localparam int EN_BIT       = 0;
  localparam int METHOD_BIT   = 0;
  localparam int MERGE_BIT    = 0;
  localparam int HALO_BIT     = 1;
  localparam int STAT_ODD_BIT = 0;
  localparam int STAT_RDY_BIT = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [OFFSET_W-1:0] RST_LUMA_OFFSET   = 11'h000;
  localparam logic [OFFSET_W-1:0] RST_CHROMA_OFFSET = 11'h080;
  localparam logic [FMT_W-1:0]    FMT_YCBCR         = 2'h3;
  localparam int GAIN_FRAC   = 4;
  localparam int SHARP_SHIFT = 6;
  localparam logic signed [23:0] PIX_MAX = 24'h00_00ff;

  typedef struct packed {
    logic [PIX_W-1:0] luma;
    logic [PIX_W-1:0] chroma;
    logic             chroma_is_cr;
    logic             chroma_midway;
  } yeecfg_pix_t;
endpackage

//--- include/yeecfg_stream_if.sv
// Valid/ready stream of finished output pixels
`timescale 1ns/10ps
`default_nettype none
interface yeecfg_stream_if;
  import yeecfg_pkg::*;
  yeecfg_pix_t data;
  logic        valid;
  logic        ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

//--- rtl/yeecfg_skid.sv
// Two-entry output buffer between the pixel stage and the receiver
`timescale 1ns/10ps
`default_nettype none
module yeecfg_skid
  import yeecfg_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  yeecfg_stream_if.snk     up,
  yeecfg_stream_if.src     dn
);
  typedef struct packed {
    yeecfg_pix_t slot0;
    yeecfg_pix_t slot1;
    logic        full0;
    logic        full1;
  } yeecfg_skid_t;

  yeecfg_skid_t state;
  yeecfg_skid_t next_state;
  logic         push;
  logic         pop;

  // Ready is a flop, so it never depends on the receiver combinationally
  assign up.ready = ~state.full1;
  assign dn.valid = state.full0;
  assign dn.data  = state.slot0;
  assign push     = up.valid & ~state.full1;
  assign pop      = state.full0 & dn.ready;

  always_comb
  begin
    next_state = state;
    if (pop)
    begin
      next_state.slot0 = state.slot1;
      next_state.full0 = state.full1;
      next_state.full1 = 1'b0;
    end
    if (push)
    begin
      if (!next_state.full0)
      begin
        next_state.slot0 = up.data;
        next_state.full0 = 1'b1;
      end
      else
      begin
        next_state.slot1 = up.data;
        next_state.full1 = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state <= '0;
    else
      state <= next_state;
  end
endmodule
`default_nettype wire

//--- rtl/yeecfg_top.sv
// Configuration registers and pixel stage: offsets, chroma resampling, tone and edge
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (R1) Add signed 11-bit luma offset, reset zero
// (R2) Add signed 11-bit Cb offset, reset 128
// (R3) Add signed 11-bit Cr offset, reset 128
// (R4) Phase bit 1 enables 1-2-1 chroma low-pass, except with source format 3
// (R5) Phase bit 0: co-sited or midway chroma
// (R6) Source format 3: bit gives input phase
// (R7) Tone stage works only when enabled
// (R8) Method 0: luma from table, chroma kept
// (R9) Method 1: table gain on all, luma-indexed
// (R10) Edge enhancer works only when enabled
// (R11) Method bit 1 enables sharpener halo reduction
// (R12) Merge bit: larger magnitude or sum
// (R13) High-pass result shifted right 0 to 15
// (R14) Coefficients 00..20 signed 10-bit, reset zero
// (R15) Software writes zero to reserved bits
// (R16) Coefficients 21, 22 signed 10-bit too
// (R17) Nine coefficients form row/column 3x3 kernel
// (R18) Edge disabled passes luma unchanged
module yeecfg_top
  import yeecfg_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [ADDR_W-1:0]      i_addr,
  input  wire logic [DATA_W-1:0]      i_wr_data,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [DATA_W-1:0]      o_rd_data,
  input  wire logic                   i_pix_valid,
  output logic                        o_pix_ready,
  input  wire logic [TAPS*PIX_W-1:0]  i_luma_nbhd,
  input  wire logic [CHR_W-1:0]       i_cb,
  input  wire logic [CHR_W-1:0]       i_cr,
  output logic                        o_pix_valid,
  input  wire logic                   i_out_ready,
  output logic      [PIX_W-1:0]       o_luma,
  output logic      [PIX_W-1:0]       o_chroma,
  output logic                        o_chroma_is_cr,
  output logic                        o_chroma_midway
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [OFFSET_W-1:0]               luma_off;
    logic [OFFSET_W-1:0]               cb_off;
    logic [OFFSET_W-1:0]               cr_off;
    logic                              lpf_en;
    logic                              chroma_pos;
    logic                              tone_en;
    logic                              tone_method;
    logic                              edge_en;
    logic                              halo_reduce;
    logic                              merge_sum;
    logic [SHIFT_W-1:0]                hpf_shift;
    logic [TAPS-1:0][COEF_W-1:0]       coef;
    logic [FMT_W-1:0]                  source_format_select;
    logic [TABLE_N-1:0][TABLE_W-1:0]   table_mem;
    logic [CHR_W-1:0]                  cb_p1;
    logic [CHR_W-1:0]                  cb_p2;
    logic [CHR_W-1:0]                  cr_p1;
    logic [CHR_W-1:0]                  cr_p2;
    logic [CHR_W-1:0]                  cb_last;
    logic [CHR_W-1:0]                  cr_last;
    logic [CHR_W-1:0]                  cr_hold;
    logic                              odd;
    logic [15:0]                       pix_count;
    logic [DATA_W-1:0]                 rd_data;
  } yeecfg_state_t;

  yeecfg_state_t state;
  yeecfg_state_t next_state;

  yeecfg_stream_if up_if ();
  yeecfg_stream_if dn_if ();

  yeecfg_skid u_skid (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .up        (up_if.snk),
    .dn        (dn_if.src)
  );

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [PIX_W-1:0] sat8(input logic signed [23:0] v);
    if (v < 0)
      return 8'h00;
    else if (v > PIX_MAX)
      return 8'hff;
    else
      return v[PIX_W-1:0];
  endfunction

  function automatic logic signed [23:0] absv(input logic signed [23:0] v);
    return (v < 0) ? -v : v;
  endfunction

  function automatic logic signed [CHR_W-1:0] filt121(input logic signed [CHR_W-1:0] a,
                                                      input logic signed [CHR_W-1:0] b,
                                                      input logic signed [CHR_W-1:0] c);
    logic signed [10:0] s;
    s = 11'(a) + (11'(b) <<< 1) + 11'(c);
    return s[10:2];
  endfunction

  function automatic logic signed [CHR_W-1:0] mid(input logic signed [CHR_W-1:0] a,
                                                  input logic signed [CHR_W-1:0] b);
    logic signed [9:0] s;
    s = 10'(a) + 10'(b);
    return s[9:1];
  endfunction

  // ----------------------------------------------------------------
  // Pixel stage
  // ----------------------------------------------------------------
  logic signed [23:0]    acc;
  logic signed [23:0]    hp;
  logic signed [23:0]    sh;
  logic signed [23:0]    merged;
  logic [PIX_W-1:0]      center;
  logic [PIX_W-1:0]      y_edge;
  logic [TABLE_W-1:0]    entry;
  logic signed [23:0]    y_tone;
  logic signed [CHR_W-1:0] cb_f;
  logic signed [CHR_W-1:0] cr_f;
  logic signed [CHR_W-1:0] cb_sel;
  logic signed [CHR_W-1:0] cr_sel;
  logic signed [CHR_W-1:0] c_sel;
  logic signed [23:0]    c_tone;
  logic                  is_ycbcr;
  logic                  push;
  yeecfg_pix_t           pix;

  always_comb
  begin
    center = i_luma_nbhd[4*PIX_W +: PIX_W];
    // Row-major taps: tap index is row*3+column of the neighbourhood
    acc = '0;
    for (int i = 0; i < TAPS; i++)
      acc = acc + 24'(signed'(state.coef[i]))
                * signed'({16'h0000, i_luma_nbhd[i*PIX_W +: PIX_W]}); // (R17) (R14) (R16)
    hp = acc >>> state.hpf_shift; // (R13)
    sh = acc >>> SHARP_SHIFT;
    // Halo reduction keeps the sharpener from overshooting the enhancer
    if (state.halo_reduce && (absv(sh) > absv(hp))) // (R11)
      sh = (sh < 0) ? -absv(hp) : absv(hp);
    if (state.merge_sum) // (R12)
      merged = hp + sh;
    else
      merged = (absv(hp) > absv(sh)) ? hp : sh;
    if (state.edge_en) // (R10)
      y_edge = sat8(signed'({16'h0000, center}) + merged);
    else
      y_edge = center; // (R18)

    // Chroma filtering and 4:2:2 phase selection
    is_ycbcr = (state.source_format_select == FMT_YCBCR);
    if (state.lpf_en && !is_ycbcr) // (R4)
    begin
      cb_f = filt121(state.cb_p2, state.cb_p1, i_cb);
      cr_f = filt121(state.cr_p2, state.cr_p1, i_cr);
    end
    else
    begin
      cb_f = i_cb;
      cr_f = i_cr;
    end
    // Already 4:2:2 input is not resampled; the phase bit only labels it
    if (state.chroma_pos && !is_ycbcr) // (R5) (R6)
    begin
      cb_sel = mid(state.cb_last, cb_f);
      cr_sel = mid(state.cr_last, cr_f);
    end
    else
    begin
      cb_sel = cb_f;
      cr_sel = cr_f;
    end
    if (!state.odd)
      c_sel = cb_sel;
    else if (is_ycbcr)
      c_sel = i_cr;
    else
      c_sel = state.cr_hold;

    // Tone stage, table indexed by the luma entering it
    entry = state.table_mem[y_edge[PIX_W-1 -: 4]];
    y_tone = signed'({16'h0000, y_edge});
    c_tone = 24'(c_sel);
    if (state.tone_en) // (R7)
    begin
      if (!state.tone_method)
        y_tone = signed'({16'h0000, entry}); // (R8)
      else
      begin
        y_tone = (signed'({16'h0000, y_edge}) * signed'({16'h0000, entry})) >>> GAIN_FRAC; // (R9)
        c_tone = (24'(c_sel) * signed'({16'h0000, entry})) >>> GAIN_FRAC; // (R9)
      end
    end

    pix.luma          = sat8(y_tone + 24'(signed'(state.luma_off))); // (R1)
    if (state.odd)
      pix.chroma      = sat8(c_tone + 24'(signed'(state.cr_off))); // (R3)
    else
      pix.chroma      = sat8(c_tone + 24'(signed'(state.cb_off))); // (R2)
    pix.chroma_is_cr  = state.odd;
    pix.chroma_midway = state.chroma_pos; // (R6)
  end

  assign up_if.valid  = i_pix_valid;
  assign up_if.data   = pix;
  assign dn_if.ready  = i_out_ready;
  assign push         = i_pix_valid & up_if.ready;

  assign o_pix_ready     = up_if.ready;
  assign o_pix_valid     = dn_if.valid;
  assign o_luma          = dn_if.data.luma;
  assign o_chroma        = dn_if.data.chroma;
  assign o_chroma_is_cr  = dn_if.data.chroma_is_cr;
  assign o_chroma_midway = dn_if.data.chroma_midway;
  assign o_rd_data       = state.rd_data;

  // ----------------------------------------------------------------
  // Register bus and next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (push)
    begin
      next_state.cb_p2     = state.cb_p1;
      next_state.cb_p1     = i_cb;
      next_state.cr_p2     = state.cr_p1;
      next_state.cr_p1     = i_cr;
      next_state.cb_last   = cb_f;
      next_state.cr_last   = cr_f;
      if (!state.odd)
        next_state.cr_hold = cr_sel;
      next_state.odd       = ~state.odd;
      next_state.pix_count = state.pix_count + 16'h0001;
    end

    // Reserved bits are dropped on write and read back as zero
    if (i_wr) // (R15)
    begin
      if (i_addr[ADDR_W-1 -: 2] == TABLE_REGION)
        next_state.table_mem[i_addr[5:2]] = i_wr_data[TABLE_W-1:0];
      else if ((i_addr >= OFS_EDGE_HPF_COEF_BASE) && (i_addr < OFS_SOURCE_FORMAT_SELECT))
        next_state.coef[4'(8'(i_addr - OFS_EDGE_HPF_COEF_BASE) >> 2)] = i_wr_data[COEF_W-1:0];
      else
      begin
        case (i_addr)
          OFS_LUMA_OUTPUT_OFFSET:      next_state.luma_off    = i_wr_data[OFFSET_W-1:0];
          OFS_BLUE_DIFF_OUTPUT_OFFSET: next_state.cb_off      = i_wr_data[OFFSET_W-1:0];
          OFS_RED_DIFF_OUTPUT_OFFSET:  next_state.cr_off      = i_wr_data[OFFSET_W-1:0];
          OFS_CHROMA_PHASE_CONTROL:
          begin
            next_state.lpf_en     = i_wr_data[PHS_LPF_BIT];
            next_state.chroma_pos = i_wr_data[PHS_POS_BIT];
          end
          OFS_TONE_ENHANCE_ENABLE:     next_state.tone_en     = i_wr_data[EN_BIT];
          OFS_TONE_ENHANCE_METHOD:     next_state.tone_method = i_wr_data[METHOD_BIT];
          OFS_EDGE_ENABLE:             next_state.edge_en     = i_wr_data[EN_BIT];
          OFS_EDGE_METHOD:
          begin
            next_state.halo_reduce = i_wr_data[HALO_BIT];
            next_state.merge_sum   = i_wr_data[MERGE_BIT];
          end
          OFS_EDGE_HPF_SHIFT:          next_state.hpf_shift   = i_wr_data[SHIFT_W-1:0];
          OFS_SOURCE_FORMAT_SELECT:    next_state.source_format_select     = i_wr_data[FMT_W-1:0];
          default:                     next_state.source_format_select     = state.source_format_select;
        endcase
      end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    next_state.rd_data = '0;
    if (i_rd)
    begin
      if (i_addr[ADDR_W-1 -: 2] == TABLE_REGION)
        next_state.rd_data = 32'(state.table_mem[i_addr[5:2]]);
      else if ((i_addr >= OFS_EDGE_HPF_COEF_BASE) && (i_addr < OFS_SOURCE_FORMAT_SELECT))
        next_state.rd_data = 32'(state.coef[4'(8'(i_addr - OFS_EDGE_HPF_COEF_BASE) >> 2)]);
      else
      begin
        case (i_addr)
          OFS_LUMA_OUTPUT_OFFSET:      next_state.rd_data = 32'(state.luma_off);
          OFS_BLUE_DIFF_OUTPUT_OFFSET: next_state.rd_data = 32'(state.cb_off);
          OFS_RED_DIFF_OUTPUT_OFFSET:  next_state.rd_data = 32'(state.cr_off);
          OFS_CHROMA_PHASE_CONTROL:    next_state.rd_data = 32'({state.lpf_en, state.chroma_pos});
          OFS_TONE_ENHANCE_ENABLE:     next_state.rd_data = 32'(state.tone_en);
          OFS_TONE_ENHANCE_METHOD:     next_state.rd_data = 32'(state.tone_method);
          OFS_EDGE_ENABLE:             next_state.rd_data = 32'(state.edge_en);
          OFS_EDGE_METHOD:             next_state.rd_data = 32'({state.halo_reduce, state.merge_sum});
          OFS_EDGE_HPF_SHIFT:          next_state.rd_data = 32'(state.hpf_shift);
          OFS_SOURCE_FORMAT_SELECT:    next_state.rd_data = 32'(state.source_format_select);
          OFS_PIPE_STATUS:
          begin
            next_state.rd_data[STAT_ODD_BIT]         = state.odd;
            next_state.rd_data[STAT_RDY_BIT]         = up_if.ready;
            next_state.rd_data[STAT_CNT_LSB +: 16]   = state.pix_count;
          end
          default:                     next_state.rd_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state          <= '0;
      state.luma_off <= RST_LUMA_OFFSET; // (R1)
      state.cb_off   <= RST_CHROMA_OFFSET; // (R2)
      state.cr_off   <= RST_CHROMA_OFFSET; // (R3)
    end
    else
      state <= next_state;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench: register map, pixel arithmetic, output buffer
`timescale 1ns/10ps
`default_nettype none
module testbench
  import yeecfg_pkg::*;
;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst_b   = 1'b0;
  logic [ADDR_W-1:0]     addr      = '0;
  logic [DATA_W-1:0]     wdata     = '0;
  logic                  wr        = 1'b0;
  logic                  rd        = 1'b0;
  logic                  pvalid    = 1'b0;
  logic                  stall     = 1'b0;
  logic [TAPS*PIX_W-1:0] nbhd      = '0;
  logic [CHR_W-1:0]      chr       = '0;
  logic [DATA_W-1:0]     rdata;
  logic                  pready, ovalid, oready, is_cr, mid, exp_cr;
  logic [PIX_W-1:0]      luma, chroma;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  int                    beat = 0;
  yeecfg_pix_t           r;

  always #12.5 i_sys_clk = ~i_sys_clk;

  yeecfg_top DUT (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_pix_valid(pvalid), .o_pix_ready(pready),
    .i_luma_nbhd(nbhd), .i_cb(chr), .i_cr(chr), .o_pix_valid(ovalid), .i_out_ready(oready),
    .o_luma(luma), .o_chroma(chroma), .o_chroma_is_cr(is_cr), .o_chroma_midway(mid)
  );
  yeecfg_sink_model sink (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_valid(ovalid),
    .i_data({luma, chroma, is_cr, mid}), .i_stall(stall), .o_ready(oready)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_sys_clk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_sys_clk);
    rd   <= 1'b0;
    @(negedge i_sys_clk);
    chk($sformatf("reg %h", a), rdata, exp);
  endtask
  // Centre tap is tap 4, the tap above it is tap 1
  task automatic pix(input logic [7:0] c, input logic [7:0] top, input logic [8:0] ch);
    int n;
    @(posedge i_sys_clk);
    n = sink.got.size();
    pvalid <= 1'b1;
    nbhd   <= {32'h0000_0000, c, 16'h0000, top, 8'h00};
    chr    <= ch;
    do @(negedge i_sys_clk); while (!pready);
    @(posedge i_sys_clk);
    pvalid <= 1'b0;
    repeat (20) if (sink.got.size() == n) @(negedge i_sys_clk);
    chk("count", sink.got.size(), 32'(n + 1));
    r = sink.got.pop_front();
    exp_cr = beat[0];
    beat++;
    chk("side", r.chroma_is_cr, exp_cr);
  endtask
  function automatic logic [31:0] mask(input int i);
    case (i)
      0, 1, 2: return 32'h0000_07ff;
      3, 7:    return 32'h0000_0003;
      4, 5, 6: return 32'h0000_0001;
      8:       return 32'h0000_000f;
      default: return 32'h0000_03ff;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    for (int i = 0; i < 20; i++)
      rreg(8'(4 * i), (i == 1 || i == 2) ? 32'h0000_0080 :
           32'(i == 19) << 1);
    for (int i = 0; i < 18; i++)
    begin
      wreg(8'(4 * i), mask(i));
      rreg(8'(4 * i), mask(i));
      wreg(8'(4 * i), (i == 1 || i == 2) ? 32'h0000_0080 : 32'h0000_0000);
    end
    wreg(8'h50, 32'hffff_ffff);
    rreg(8'h50, 32'h0000_0000);
  endtask
  task automatic t_offsets;
    pix(8'h40, 8'h00, 9'h010);
    chk("luma", r.luma, 8'h40);
    chk("chroma", r.chroma, 8'h90);
    wreg(OFS_LUMA_OUTPUT_OFFSET, 32'h0000_07fb);
    pix(8'h40, 8'h00, 9'h000);
    chk("luma", r.luma, 8'h3b);
    pix(8'h03, 8'h00, 9'h010);
    chk("luma", r.luma, 8'h00);
    wreg(OFS_LUMA_OUTPUT_OFFSET, 32'h0000_0000);
    wreg(OFS_RED_DIFF_OUTPUT_OFFSET, 32'h0000_0000);
    repeat (2)
    begin
      pix(8'h40, 8'h00, 9'h010);
      chk("chroma", r.chroma, exp_cr ? 8'h10 : 8'h90);
    end
    wreg(OFS_RED_DIFF_OUTPUT_OFFSET, 32'h0000_0080);
  endtask
  task automatic t_edge;
    logic [7:0] m[6] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h00, 8'h00};
    logic [7:0] s[6] = '{8'h00, 8'h00, 8'h0f, 8'h0f, 8'h04, 8'h00};
    logic [9:0] k[6] = '{10'h001, 10'h001, 10'h001, 10'h001, 10'h001, 10'h3ff};
    logic [7:0] y[6] = '{8'h60, 8'h61, 8'h21, 8'h20, 8'h24, 8'h00};
    wreg(OFS_EDGE_ENABLE, 32'h0000_0001);
    for (int i = 0; i < 6; i++)
    begin
      wreg(OFS_EDGE_METHOD, 32'(m[i]));
      wreg(OFS_EDGE_HPF_SHIFT, 32'(s[i]));
      wreg(OFS_EDGE_HPF_COEF_BASE + 8'h04, 32'(k[i]));
      pix(8'h20, 8'h40, 9'h000);
      chk("luma", r.luma, y[i]);
    end
    wreg(OFS_EDGE_ENABLE, 32'h0000_0000);
    pix(8'h20, 8'h40, 9'h000);
    chk("luma", r.luma, 8'h20);
  endtask
  task automatic t_tone;
    wreg(OFS_TONE_TABLE_BASE + 8'h08, 32'h0000_0077);
    pix(8'h25, 8'h00, 9'h010);
    chk("luma", r.luma, 8'h25);
    wreg(OFS_TONE_ENHANCE_ENABLE, 32'h0000_0001);
    pix(8'h25, 8'h00, 9'h010);
    chk("luma", r.luma, 8'h77);
    chk("chroma", r.chroma, 8'h90);
    wreg(OFS_TONE_ENHANCE_METHOD, 32'h0000_0001);
    wreg(OFS_TONE_TABLE_BASE + 8'h08, 32'h0000_0020);
    pix(8'h25, 8'h00, 9'h010);
    chk("luma", r.luma, 8'h4a);
    chk("chroma", r.chroma, 8'ha0);
    wreg(OFS_TONE_ENHANCE_ENABLE, 32'h0000_0000);
  endtask
  task automatic t_chroma;
    wreg(OFS_CHROMA_PHASE_CONTROL, 32'h0000_0002);
    repeat (3) pix(8'h40, 8'h00, 9'h000);
    pix(8'h40, 8'h00, 9'h040);
    chk("chroma", r.chroma, 8'h90);
    wreg(OFS_CHROMA_PHASE_CONTROL, 32'h0000_0001);
    pix(8'h40, 8'h00, 9'h000);
    pix(8'h40, 8'h00, 9'h040);
    chk("chroma", r.chroma, 8'ha0);
    chk("midway", r.chroma_midway, 1'b1);
    wreg(OFS_SOURCE_FORMAT_SELECT, 32'h0000_0003);
    pix(8'h40, 8'h00, 9'h000);
    pix(8'h40, 8'h00, 9'h040);
    chk("chroma", r.chroma, 8'hc0);
    wreg(OFS_CHROMA_PHASE_CONTROL, 32'h0000_0000);
    wreg(OFS_SOURCE_FORMAT_SELECT, 32'h0000_0000);
    pix(8'h40, 8'h00, 9'h040);
    chk("chroma", r.chroma, 8'hc0);
    chk("midway", r.chroma_midway, 1'b0);
  endtask
  // Receiver stalls: two words buffered, the third refused, none lost
  task automatic t_stall;
    int   n = 0;
    logic tk;
    @(posedge i_sys_clk);
    stall  <= 1'b1;
    pvalid <= 1'b1;
    nbhd   <= {32'h0000_0000, 8'h11, 32'h0000_0000};
    repeat (8)
    begin
      @(negedge i_sys_clk);
      tk = pready;
      @(posedge i_sys_clk);
      if (tk)
        n++;
      nbhd[39:32] <= 8'h22;
    end
    chk("taken", 32'(n), 32'h0000_0002);
    @(negedge i_sys_clk);
    chk("ready", pready, 1'b0);
    @(posedge i_sys_clk);
    stall <= 1'b0;
    do @(negedge i_sys_clk); while (!pready);
    @(posedge i_sys_clk);
    pvalid <= 1'b0;
    repeat (10) @(negedge i_sys_clk);
    chk("drained", sink.got.size(), 32'h0000_0003);
    r = sink.got.pop_front();
    chk("first", r.luma, 8'h11);
    r = sink.got.pop_front();
    chk("second", r.luma, 8'h22);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_map();
    t_offsets();
    t_edge();
    t_tone();
    t_chroma();
    t_stall();
    tally_and_finish();
  end
  // About sixty times the expected run length means a hang
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- tb/yeecfg_assertions.sv
// Port-level checks for the configuration and pixel block
`timescale 1ns/10ps
`default_nettype none
module yeecfg_assertions
  import yeecfg_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rd,
  input  wire logic [DATA_W-1:0] o_rd_data,
  input  wire logic              i_pix_valid,
  input  wire logic              o_pix_ready,
  input  wire logic              o_pix_valid,
  input  wire logic              i_out_ready,
  input  wire logic [PIX_W-1:0]  o_luma,
  input  wire logic [PIX_W-1:0]  o_chroma,
  input  wire logic              o_chroma_is_cr
);
  default clocking dclk @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------------------------------
  // Reserved bits and stream handshake
  // ----------------------------------------------------------------
  off_resv_a: assert property (
    $past(i_rd) && $past(i_addr) inside {8'h00, 8'h04, 8'h08} |-> o_rd_data[31:11] == '0)
    else $error("Offset reserved bits not zero");
  phase_resv_a: assert property (
    $past(i_rd) && $past(i_addr) inside {8'h0c, 8'h1c} |-> o_rd_data[31:2] == '0)
    else $error("Phase or method reserved bits not zero");
  en_resv_a: assert property (
    $past(i_rd) && $past(i_addr) inside {8'h10, 8'h14, 8'h18} |-> o_rd_data[31:1] == '0)
    else $error("Enable reserved bits not zero");
  shift_resv_a: assert property (
    $past(i_rd) && $past(i_addr) == OFS_EDGE_HPF_SHIFT |-> o_rd_data[31:4] == '0)
    else $error("Shift reserved bits not zero");
  coef_resv_a: assert property (
    $past(i_rd) && $past(i_addr) inside {[8'h24:8'h44]} |-> o_rd_data[31:10] == '0)
    else $error("Coefficient reserved bits not zero");
  // A stalled word must not change, or a sample would be lost
  out_hold_a: assert property (
    o_pix_valid && !i_out_ready |=> o_pix_valid && $stable(o_luma) && $stable(o_chroma))
    else $error("Output changed while stalled");
  take_lat_a: assert property (
    i_pix_valid && o_pix_ready && !o_pix_valid |=> o_pix_valid)
    else $error("Taken pixel did not appear next cycle");
  beat_alt_a: assert property (
    o_pix_valid && i_out_ready ##1 o_pix_valid |-> o_chroma_is_cr != $past(o_chroma_is_cr))
    else $error("Chroma side did not alternate");
  cover property (o_pix_valid && !i_out_ready && !o_pix_ready);
  cover property ($past(i_rd) && $past(i_addr) == OFS_EDGE_HPF_SHIFT);
  cover property (o_pix_valid && i_out_ready ##1 o_pix_valid);
endmodule
bind yeecfg_top yeecfg_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd),
  .o_rd_data(o_rd_data), .i_pix_valid(i_pix_valid), .o_pix_ready(o_pix_ready),
  .o_pix_valid(o_pix_valid), .i_out_ready(i_out_ready), .o_luma(o_luma),
  .o_chroma(o_chroma), .o_chroma_is_cr(o_chroma_is_cr)
);
`default_nettype wire

//--- tb/yeecfg_sink_model.sv
// Downstream stage model: collects finished pixels, stalls on command
`timescale 1ns/10ps
`default_nettype none
module yeecfg_sink_model
  import yeecfg_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_valid,
  input  wire yeecfg_pix_t i_data,
  input  wire logic        i_stall,
  output logic             o_ready
);
  yeecfg_pix_t got[$];
  // Stalling is the only way to fill the output buffer
  assign o_ready = !i_stall;
  always @(posedge i_sys_clk)
  begin
    if (i_rst_b && i_valid && o_ready)
      got.push_back(i_data);
  end
endmodule
`default_nettype wire
